// [rtl/malu_pkg.sv]
package malu_pkg;
    // APB byte offsets
    localparam logic [7:0] OFF_INSTR     = 8'h00;
    localparam logic [7:0] OFF_WORK      = 8'h04;
    localparam logic [7:0] OFF_STATUS    = 8'h08;
    localparam logic [7:0] OFF_TBLPTR    = 8'h0c;
    localparam logic [7:0] OFF_TBLHIGH   = 8'h10;
    localparam logic [7:0] OFF_PAGE      = 8'h14;
    localparam logic [7:0] OFF_MEM_PTR   = 8'h18;
    localparam logic [7:0] OFF_MEM_DATA  = 8'h1c;
    localparam logic [7:0] OFF_PROG_PTR  = 8'h20;
    localparam logic [7:0] OFF_PROG_DATA = 8'h24;
    localparam logic [7:0] OFF_CYCLES    = 8'h28;
    // Memory geometry
    localparam int unsigned DMEM_AW    = 6;
    localparam int unsigned DMEM_DEPTH = 64;
    localparam int unsigned PAGE_W     = 2;
    localparam int unsigned PMEM_AW    = 10;
    localparam int unsigned PMEM_DEPTH = 1024;
    localparam logic [1:0]  LAST_PAGE  = 2'h3;
    // Instruction word fields
    localparam int unsigned INSTR_OP_LSB   = 0;
    localparam int unsigned INSTR_BIT_LSB  = 5;
    localparam int unsigned INSTR_ADDR_LSB = 8;
    localparam int unsigned INSTR_IMM_LSB  = 16;
    // Status word fields
    localparam int unsigned ST_CARRY = 0;
    localparam int unsigned ST_HALF  = 1;
    localparam int unsigned ST_ZERO  = 2;
    localparam int unsigned ST_RANGE = 3;
    localparam int unsigned ST_BUSY  = 8;
    localparam int unsigned ST_SKIP  = 9;
    localparam logic [7:0]  ALL_ONES = 8'hff;
    localparam logic [7:0]  ONE_BIT  = 8'h01;
    localparam logic [31:0] RD_ZERO  = 32'h0000_0000;

    typedef enum logic [4:0] {
        OP_NOP           = 5'h00,
        OP_ROT_RC_W      = 5'h01,
        OP_SUB_BORROW    = 5'h02,
        OP_SUB_BORROW_M  = 5'h03,
        OP_DIFF          = 5'h04,
        OP_DIFF_M        = 5'h05,
        OP_DIFF_IMM      = 5'h06,
        OP_DEC_SKIP      = 5'h07,
        OP_DEC_W_SKIP    = 5'h08,
        OP_INC_SKIP      = 5'h09,
        OP_INC_W_SKIP    = 5'h0a,
        OP_SKIP_BIT_SET  = 5'h0b,
        OP_SKIP_ZERO     = 5'h0c,
        OP_LOAD_W_SKIP   = 5'h0d,
        OP_SKIP_BIT_CLR  = 5'h0e,
        OP_SET_BYTE      = 5'h0f,
        OP_SET_BIT       = 5'h10,
        OP_TBL_CUR       = 5'h11,
        OP_TBL_LAST      = 5'h12,
        OP_SWAP          = 5'h13,
        OP_SWAP_W        = 5'h14,
        OP_XOR           = 5'h15,
        OP_XOR_IMM       = 5'h16,
        OP_XOR_M         = 5'h17
    } malu_op_type;

    typedef enum logic [1:0] {
        FSM_IDLE  = 2'b00,
        FSM_EXEC  = 2'b01,
        FSM_DUMMY = 2'b10
    } malu_fsm_type;
endpackage

// [rtl/malu_core.sv]
// Functional notes
// RL1: Rotate right via carry into working; carry gets memory bit 0.
// RL2: Subtract with borrow: working plus inverted memory plus carry, to working or memory.
// RL3: Difference with memory: working plus inverted memory plus one, flags updated.
// RL4: Difference with immediate into working, four arithmetic flags updated.
// RL5: Decrement memory in place, skip when zero, flags kept.
// RL6: Decrement into working, memory kept, skip when zero.
// RL7: Increment memory in place, skip when zero, flags kept.
// RL8: Increment into working, memory kept, skip when zero.
// RL9: A taken skip discards the prefetch and adds one dummy cycle.
// RL10: Skip when selected memory bit is one.
// RL11: Skip when memory byte is zero, nothing changed.
// RL12: Copy memory to working, skip when zero.
// RL13: Skip when selected memory bit is zero.
// RL14: Byte set writes all ones, flags kept.
// RL15: Bit set forces one bit only, flags kept.
// RL16: Table read in current page: low byte to memory, high to latch.
// RL17: Table read in last page: low byte to memory, high to latch.
// RL18: Nibble swap of memory byte in place.
// RL19: Nibble-swapped memory byte to working, memory kept.
// RL20: Xor working with memory into working, zero flag only.
// RL21: Xor working with immediate into working, zero flag only.
// RL22: Xor into memory, zero flag only.
// RL23: Subtract carry is adder carry out, set means no borrow.
module malu_core (
    input  wire logic        clk_sys,        // 10 MHz system clock
    input  wire logic        reset_n,        // Async reset, active low
    input  wire logic        clk_en,         // Freezes all state when low
    input  wire logic        psel,           // APB select
    input  wire logic        penable,        // APB enable
    input  wire logic        pwrite,         // APB direction
    input  wire logic [7:0]  paddr,          // APB byte address
    input  wire logic [31:0] pwdata,         // APB write data
    output logic      [31:0] prdata,         // APB read data
    output logic             pready,         // APB ready
    output logic             pslverr,        // APB error
    output logic             fetch_discard,  // Pulse: prefetch dropped
    output logic             exec_busy       // Instruction in flight
);
    typedef struct packed {
        malu_pkg::malu_fsm_type         fsm;
        malu_pkg::malu_op_type          op;
        logic [2:0]                     bsel;
        logic [malu_pkg::DMEM_AW-1:0]   addr;
        logic [7:0]                     imm;
        logic [7:0]                     work;
        logic                           c;
        logic                           ac;
        logic                           z;
        logic                           ov;
        logic [7:0]                     table_pointer;
        logic [7:0]                     table_high_latch;
        logic [malu_pkg::PAGE_W-1:0]    page;
        logic [malu_pkg::DMEM_AW-1:0]   mem_ptr;
        logic [malu_pkg::PMEM_AW-1:0]   prog_ptr;
        logic [15:0]                    cycles;
        logic                           skip;
        logic                           discard;
        logic                           busy;
        logic                           pready;
        logic                           pslverr;
        logic [31:0]                    prdata;
    } malu_state_type;

    malu_state_type st;
    malu_state_type next_st;

    logic [7:0]  dmem [malu_pkg::DMEM_DEPTH];
    logic [15:0] pmem [malu_pkg::PMEM_DEPTH];

    logic                         mem_we;
    logic [malu_pkg::DMEM_AW-1:0] mem_wa;
    logic [7:0]                   mem_wd;
    logic                         prog_we;
    logic [7:0]                   opnd;
    logic [15:0]                  pword;
    logic [10:0]                  arith;
    logic                         fire;

    // Adder with inverted second operand: {ov, ac, c, result}
    function automatic logic [10:0] sub8(input logic [7:0] a, input logic [7:0] b, input logic cin);
        logic [8:0] sum;
        logic [4:0] low;
        logic       ovf;
        sum = {1'b0, a} + {1'b0, ~b} + {8'h00, cin};
        low = {1'b0, a[3:0]} + {1'b0, ~b[3:0]} + {4'h0, cin};
        ovf = (a[7] == ~b[7]) && (sum[7] != a[7]);
        return {ovf, low[4], sum[8], sum[7:0]};
    endfunction

    function automatic logic known_reg(input logic [7:0] a);
        return (a == malu_pkg::OFF_INSTR) || (a == malu_pkg::OFF_WORK) || (a == malu_pkg::OFF_STATUS)
            || (a == malu_pkg::OFF_TBLPTR) || (a == malu_pkg::OFF_TBLHIGH) || (a == malu_pkg::OFF_PAGE)
            || (a == malu_pkg::OFF_MEM_PTR) || (a == malu_pkg::OFF_MEM_DATA)
            || (a == malu_pkg::OFF_PROG_PTR) || (a == malu_pkg::OFF_PROG_DATA)
            || (a == malu_pkg::OFF_CYCLES);
    endfunction

    assign opnd = dmem[st.addr];
    assign fire = clk_en && (st.fsm == malu_pkg::FSM_EXEC);
    // RL16 RL17 page select
    assign pword = pmem[{(st.op == malu_pkg::OP_TBL_LAST) ? malu_pkg::LAST_PAGE : st.page, st.table_pointer}];
    // RL2 RL23 carry in
    assign arith = sub8(st.work, (st.op == malu_pkg::OP_DIFF_IMM) ? st.imm : opnd,
                        (st.op == malu_pkg::OP_SUB_BORROW || st.op == malu_pkg::OP_SUB_BORROW_M) ? st.c : 1'b1);

    always_comb begin
        next_st = st;
        next_st.pready = 1'b0;
        next_st.discard = 1'b0;
        mem_we = 1'b0;
        mem_wa = st.addr;
        mem_wd = 8'h00;
        prog_we = 1'b0;
        // Wait states while busy keep register traffic away from a running op
        if (psel && !st.pready && st.fsm == malu_pkg::FSM_IDLE) begin
            next_st.pready = 1'b1;
            next_st.pslverr = !known_reg(paddr)
                || (pwrite && paddr == malu_pkg::OFF_INSTR
                    && pwdata[malu_pkg::INSTR_OP_LSB +: 5] > malu_pkg::OP_XOR_M);
            case (paddr)
                malu_pkg::OFF_WORK:      next_st.prdata = {24'h0, st.work};
                malu_pkg::OFF_STATUS:    next_st.prdata = {22'h0, st.skip, st.busy, 4'h0, st.ov, st.z, st.ac, st.c};
                malu_pkg::OFF_TBLPTR:    next_st.prdata = {24'h0, st.table_pointer};
                malu_pkg::OFF_TBLHIGH:   next_st.prdata = {24'h0, st.table_high_latch};
                malu_pkg::OFF_PAGE:      next_st.prdata = {30'h0, st.page};
                malu_pkg::OFF_MEM_PTR:   next_st.prdata = {26'h0, st.mem_ptr};
                malu_pkg::OFF_MEM_DATA:  next_st.prdata = {24'h0, dmem[st.mem_ptr]};
                malu_pkg::OFF_PROG_PTR:  next_st.prdata = {22'h0, st.prog_ptr};
                malu_pkg::OFF_PROG_DATA: next_st.prdata = {16'h0, pmem[st.prog_ptr]};
                malu_pkg::OFF_CYCLES:    next_st.prdata = {16'h0, st.cycles};
                default:                 next_st.prdata = malu_pkg::RD_ZERO;
            endcase
        end
        if (psel && penable && st.pready && pwrite && !st.pslverr) begin
            case (paddr)
                malu_pkg::OFF_INSTR: begin
                    next_st.op   = malu_pkg::malu_op_type'(pwdata[malu_pkg::INSTR_OP_LSB +: 5]);
                    next_st.bsel = pwdata[malu_pkg::INSTR_BIT_LSB +: 3];
                    next_st.addr = pwdata[malu_pkg::INSTR_ADDR_LSB +: malu_pkg::DMEM_AW];
                    next_st.imm  = pwdata[malu_pkg::INSTR_IMM_LSB +: 8];
                    next_st.fsm  = malu_pkg::FSM_EXEC;
                    next_st.busy = 1'b1;
                    next_st.skip = 1'b0;
                end
                malu_pkg::OFF_WORK: next_st.work = pwdata[7:0];
                malu_pkg::OFF_STATUS: begin
                    next_st.c  = pwdata[malu_pkg::ST_CARRY];
                    next_st.ac = pwdata[malu_pkg::ST_HALF];
                    next_st.z  = pwdata[malu_pkg::ST_ZERO];
                    next_st.ov = pwdata[malu_pkg::ST_RANGE];
                end
                malu_pkg::OFF_TBLPTR:   next_st.table_pointer = pwdata[7:0];
                malu_pkg::OFF_PAGE:     next_st.page = pwdata[malu_pkg::PAGE_W-1:0];
                malu_pkg::OFF_MEM_PTR:  next_st.mem_ptr = pwdata[malu_pkg::DMEM_AW-1:0];
                malu_pkg::OFF_MEM_DATA: begin
                    mem_we = 1'b1;
                    mem_wa = st.mem_ptr;
                    mem_wd = pwdata[7:0];
                end
                malu_pkg::OFF_PROG_PTR: next_st.prog_ptr = pwdata[malu_pkg::PMEM_AW-1:0];
                malu_pkg::OFF_PROG_DATA: begin
                    prog_we = 1'b1;
                    next_st.prog_ptr = st.prog_ptr + 10'h001;
                end
                default: ;
            endcase
        end
        case (st.fsm)
            malu_pkg::FSM_EXEC: begin
                next_st.cycles = st.cycles + 16'h0001;
                case (st.op)
                    // RL1 rotate via carry
                    malu_pkg::OP_ROT_RC_W: begin
                        next_st.work = {st.c, opnd[7:1]};
                        next_st.c = opnd[0];
                    end
                    // RL2 RL3 RL4 RL23 arithmetic
                    malu_pkg::OP_SUB_BORROW, malu_pkg::OP_DIFF, malu_pkg::OP_DIFF_IMM,
                    malu_pkg::OP_SUB_BORROW_M, malu_pkg::OP_DIFF_M: begin
                        if (st.op == malu_pkg::OP_SUB_BORROW_M || st.op == malu_pkg::OP_DIFF_M) begin
                            mem_we = 1'b1;
                            mem_wd = arith[7:0];
                        end else begin
                            next_st.work = arith[7:0];
                        end
                        next_st.c  = arith[8];
                        next_st.ac = arith[9];
                        next_st.ov = arith[10];
                        next_st.z  = (arith[7:0] == 8'h00);
                    end
                    // RL5 decrement in place
                    malu_pkg::OP_DEC_SKIP: begin
                        mem_we = 1'b1;
                        mem_wd = opnd - 8'h01;
                        next_st.skip = (opnd == 8'h01);
                    end
                    // RL6 decrement to working
                    malu_pkg::OP_DEC_W_SKIP: begin
                        next_st.work = opnd - 8'h01;
                        next_st.skip = (opnd == 8'h01);
                    end
                    // RL7 increment in place
                    malu_pkg::OP_INC_SKIP: begin
                        mem_we = 1'b1;
                        mem_wd = opnd + 8'h01;
                        next_st.skip = (opnd == malu_pkg::ALL_ONES);
                    end
                    // RL8 increment to working
                    malu_pkg::OP_INC_W_SKIP: begin
                        next_st.work = opnd + 8'h01;
                        next_st.skip = (opnd == malu_pkg::ALL_ONES);
                    end
                    // RL10 bit one test
                    malu_pkg::OP_SKIP_BIT_SET: next_st.skip = opnd[st.bsel];
                    // RL11 byte zero test
                    malu_pkg::OP_SKIP_ZERO: next_st.skip = (opnd == 8'h00);
                    // RL12 load and test
                    malu_pkg::OP_LOAD_W_SKIP: begin
                        next_st.work = opnd;
                        next_st.skip = (opnd == 8'h00);
                    end
                    // RL13 bit zero test
                    malu_pkg::OP_SKIP_BIT_CLR: next_st.skip = !opnd[st.bsel];
                    // RL14 byte set
                    malu_pkg::OP_SET_BYTE: begin
                        mem_we = 1'b1;
                        mem_wd = malu_pkg::ALL_ONES;
                    end
                    // RL15 single bit set
                    malu_pkg::OP_SET_BIT: begin
                        mem_we = 1'b1;
                        mem_wd = opnd | (malu_pkg::ONE_BIT << st.bsel);
                    end
                    // RL16 RL17 table read
                    malu_pkg::OP_TBL_CUR, malu_pkg::OP_TBL_LAST: begin
                        mem_we = 1'b1;
                        mem_wd = pword[7:0];
                        next_st.table_high_latch = pword[15:8];
                    end
                    // RL18 swap in place
                    malu_pkg::OP_SWAP: begin
                        mem_we = 1'b1;
                        mem_wd = {opnd[3:0], opnd[7:4]};
                    end
                    // RL19 swap to working
                    malu_pkg::OP_SWAP_W: next_st.work = {opnd[3:0], opnd[7:4]};
                    // RL20 RL21 xor to working
                    malu_pkg::OP_XOR, malu_pkg::OP_XOR_IMM: begin
                        next_st.work = st.work ^ ((st.op == malu_pkg::OP_XOR) ? opnd : st.imm);
                        next_st.z = ((st.work ^ ((st.op == malu_pkg::OP_XOR) ? opnd : st.imm)) == 8'h00);
                    end
                    // RL22 xor to memory
                    malu_pkg::OP_XOR_M: begin
                        mem_we = 1'b1;
                        mem_wd = st.work ^ opnd;
                        next_st.z = ((st.work ^ opnd) == 8'h00);
                    end
                    default: ;
                endcase
                // RL9 dummy cycle on skip
                if (next_st.skip) begin
                    next_st.fsm = malu_pkg::FSM_DUMMY;
                    next_st.discard = 1'b1;
                end else begin
                    next_st.fsm = malu_pkg::FSM_IDLE;
                    next_st.busy = 1'b0;
                end
            end
            malu_pkg::FSM_DUMMY: begin
                next_st.cycles = st.cycles + 16'h0001;
                next_st.fsm = malu_pkg::FSM_IDLE;
                next_st.busy = 1'b0;
            end
            default: ;
        endcase
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            st <= '0;
        end else if (clk_en) begin
            st <= next_st;
        end
    end

    // Arrays are not reset; software loads them before use
    always_ff @(posedge clk_sys) begin
        if (clk_en) begin
            if (mem_we) begin
                dmem[mem_wa] <= mem_wd;
            end
            if (prog_we) begin
                pmem[st.prog_ptr] <= pwdata[15:0];
            end
        end
    end

    assign prdata = st.prdata;
    assign pready = st.pready;
    assign pslverr = st.pslverr;
    assign fetch_discard = st.discard;
    assign exec_busy = st.busy;

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!reset_n);

    property p_rotate;
        fire && st.op == malu_pkg::OP_ROT_RC_W |=> st.work == {$past(st.c), $past(opnd[7:1])}
            && st.c == $past(opnd[0]) && st.z == $past(st.z);
    endproperty
    a_rotate: assert property (p_rotate) else $error("rotate through carry wrong"); // RL1

    property p_borrow;
        fire && st.op == malu_pkg::OP_SUB_BORROW
            |=> st.work == 8'($past(st.work) - $past(opnd) - {7'h00, !$past(st.c)});
    endproperty
    a_borrow: assert property (p_borrow) else $error("subtract with borrow result wrong"); // RL2

    property p_diff_carry;
        fire && st.op == malu_pkg::OP_DIFF |=> st.work == 8'($past(st.work) - $past(opnd))
            && st.c == ($past(st.work) >= $past(opnd));
    endproperty
    a_diff_carry: assert property (p_diff_carry) else $error("difference or borrow sense wrong"); // RL23

    property p_diff_imm;
        fire && st.op == malu_pkg::OP_DIFF_IMM |=> st.z == ($past(st.work) == $past(st.imm));
    endproperty
    a_diff_imm: assert property (p_diff_imm) else $error("immediate difference zero flag wrong"); // RL4

    property p_skip_dummy;
        fire && next_st.skip |=> st.fsm == malu_pkg::FSM_DUMMY && fetch_discard
            ##1 ($past(clk_en) ? st.fsm == malu_pkg::FSM_IDLE : st.fsm == malu_pkg::FSM_DUMMY);
    endproperty
    a_skip_dummy: assert property (p_skip_dummy) else $error("skip did not insert one dummy cycle"); // RL9

    property p_inc_mem;
        fire && st.op == malu_pkg::OP_INC_SKIP |=> dmem[$past(st.addr)] == 8'($past(opnd) + 8'h01)
            && {st.c, st.ac, st.z, st.ov} == $past({st.c, st.ac, st.z, st.ov});
    endproperty
    a_inc_mem: assert property (p_inc_mem) else $error("increment in place wrong"); // RL7

    property p_dec_skip;
        fire && st.op == malu_pkg::OP_DEC_W_SKIP |=> st.skip == ($past(opnd) == 8'h01)
            && st.work == 8'($past(opnd) - 8'h01);
    endproperty
    a_dec_skip: assert property (p_dec_skip) else $error("decrement to working wrong"); // RL6

    property p_set_byte;
        fire && st.op == malu_pkg::OP_SET_BYTE |=> dmem[$past(st.addr)] == malu_pkg::ALL_ONES;
    endproperty
    a_set_byte: assert property (p_set_byte) else $error("byte set not all ones"); // RL14

    property p_swap;
        fire && st.op == malu_pkg::OP_SWAP |=> dmem[$past(st.addr)] == {$past(opnd[3:0]), $past(opnd[7:4])};
    endproperty
    a_swap: assert property (p_swap) else $error("nibble swap wrong"); // RL18

    property p_xor_zero;
        fire && st.op == malu_pkg::OP_XOR |=> st.z == ($past(st.work) == $past(opnd)) && st.c == $past(st.c);
    endproperty
    a_xor_zero: assert property (p_xor_zero) else $error("xor zero flag wrong"); // RL20

    c_skip: cover property (fire && next_st.skip);
    c_table: cover property (fire && st.op == malu_pkg::OP_TBL_LAST);
    c_borrow: cover property (fire && st.op == malu_pkg::OP_SUB_BORROW_M && !st.c);
    c_wait: cover property (psel && st.fsm != malu_pkg::FSM_IDLE);
endmodule

// [bench/testbench.sv]
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clk_sys = 1'b0;
    logic        reset_n = 1'b0;
    logic        clk_en = 1'b1;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        fetch_discard;
    logic        exec_busy;
    logic [31:0] q;
    logic [31:0] q0;
    logic        err;
    int          mismatches = 0;
    int          samples_checked = 0;
    int          ticks = 0;
    int          discards = 0;

    malu_core dut (.clk_sys(clk_sys), .reset_n(reset_n), .clk_en(clk_en), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .fetch_discard(fetch_discard), .exec_busy(exec_busy));

    always #50 clk_sys = ~clk_sys;

    // Hang guard; runs well past the several hundred cycles the tests need
    always @(posedge clk_sys) begin
        ticks++;
        if (fetch_discard === 1'b1) discards++;
        if (ticks == 8000) begin
            mismatches++;
            complete_run();
        end
    end

    task automatic complete_run();
        $display("Checks %0d, mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            $display("Error at %0t: got %h, expected %h", $time, got, exp);
            mismatches++;
        end
    endtask

    // Holds the request until pready; a busy engine stretches the access
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        do @(posedge clk_sys); while (pready !== 1'b1);
        q = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic run_op(input logic [4:0] op, input logic [2:0] b, input logic [7:0] imm, input logic [7:0] mw,
        input logic [7:0] ww, input logic [3:0] st, input logic [7:0] ew, input logic [7:0] em,
        input logic [9:0] es);
        apb(1'b1, malu_pkg::OFF_MEM_PTR, 32'h0000_0003);
        apb(1'b1, malu_pkg::OFF_MEM_DATA, {24'h000000, mw});
        apb(1'b1, malu_pkg::OFF_WORK, {24'h000000, ww});
        apb(1'b1, malu_pkg::OFF_STATUS, {28'h0000000, st});
        apb(1'b1, malu_pkg::OFF_INSTR, {8'h00, imm, 8'h03, b, op});
        apb(1'b0, malu_pkg::OFF_WORK, 32'h0);
        chk(q, {24'h000000, ew});
        apb(1'b0, malu_pkg::OFF_MEM_DATA, 32'h0);
        chk(q, {24'h000000, em});
        apb(1'b0, malu_pkg::OFF_STATUS, 32'h0);
        chk(q, {22'h000000, es});
    endtask

    task automatic t_arith();
        run_op(malu_pkg::OP_SUB_BORROW, 3'h0, 8'h00, 8'h10, 8'h30, 4'h1, 8'h20, 8'h10, 10'h003);
        run_op(malu_pkg::OP_SUB_BORROW_M, 3'h0, 8'h00, 8'h10, 8'h30, 4'h0, 8'h30, 8'h1f, 10'h001);
        run_op(malu_pkg::OP_DIFF, 3'h0, 8'h00, 8'h42, 8'h42, 4'h0, 8'h00, 8'h42, 10'h007);
        run_op(malu_pkg::OP_DIFF_M, 3'h0, 8'h00, 8'h01, 8'h80, 4'h0, 8'h80, 8'h7f, 10'h009);
        run_op(malu_pkg::OP_DIFF_IMM, 3'h0, 8'h01, 8'h55, 8'h00, 4'h0, 8'hff, 8'h55, 10'h000);
    endtask

    task automatic t_skip();
        apb(1'b0, malu_pkg::OFF_CYCLES, 32'h0);
        q0 = q;
        run_op(malu_pkg::OP_DEC_SKIP, 3'h0, 8'h00, 8'h01, 8'h11, 4'h5, 8'h11, 8'h00, 10'h205);
        apb(1'b0, malu_pkg::OFF_CYCLES, 32'h0);
        chk(q - q0, 32'h0000_0002);
        run_op(malu_pkg::OP_DEC_W_SKIP, 3'h0, 8'h00, 8'h02, 8'h11, 4'h5, 8'h01, 8'h02, 10'h005);
        run_op(malu_pkg::OP_INC_SKIP, 3'h0, 8'h00, 8'hff, 8'h11, 4'h5, 8'h11, 8'h00, 10'h205);
        run_op(malu_pkg::OP_INC_W_SKIP, 3'h0, 8'h00, 8'hff, 8'h11, 4'h5, 8'h00, 8'hff, 10'h205);
        run_op(malu_pkg::OP_SKIP_BIT_SET, 3'h7, 8'h00, 8'h80, 8'h11, 4'h5, 8'h11, 8'h80, 10'h205);
        run_op(malu_pkg::OP_SKIP_ZERO, 3'h0, 8'h00, 8'h00, 8'h11, 4'h5, 8'h11, 8'h00, 10'h205);
        run_op(malu_pkg::OP_LOAD_W_SKIP, 3'h0, 8'h00, 8'h3c, 8'h11, 4'h5, 8'h3c, 8'h3c, 10'h005);
        run_op(malu_pkg::OP_SKIP_BIT_CLR, 3'h2, 8'h00, 8'hfb, 8'h11, 4'h5, 8'h11, 8'hfb, 10'h205);
        chk(discards, 32'h0000_0006);
    endtask

    // Engine must hold mid-instruction while the enable is low
    task automatic t_freeze();
        apb(1'b0, malu_pkg::OFF_CYCLES, 32'h0);
        q0 = q;
        apb(1'b1, malu_pkg::OFF_MEM_DATA, 32'h0000_0001);
        apb(1'b1, malu_pkg::OFF_INSTR, {16'h0000, 8'h03, 3'h0, malu_pkg::OP_DEC_SKIP});
        clk_en <= 1'b0;
        repeat (5) @(posedge clk_sys);
        chk({31'h0, exec_busy}, 32'h0000_0001);
        clk_en <= 1'b1;
        apb(1'b0, malu_pkg::OFF_MEM_DATA, 32'h0);
        chk(q, 32'h0000_0000);
        chk({31'h0, exec_busy}, 32'h0000_0000);
        apb(1'b0, malu_pkg::OFF_CYCLES, 32'h0);
        chk(q - q0, 32'h0000_0002);
    endtask

    task automatic t_misc();
        run_op(malu_pkg::OP_ROT_RC_W, 3'h0, 8'h00, 8'h02, 8'h00, 4'h1, 8'h81, 8'h02, 10'h000);
        run_op(malu_pkg::OP_SET_BYTE, 3'h0, 8'h00, 8'h12, 8'h00, 4'hf, 8'h00, 8'hff, 10'h00f);
        run_op(malu_pkg::OP_SET_BIT, 3'h4, 8'h00, 8'h01, 8'h00, 4'hf, 8'h00, 8'h11, 10'h00f);
        run_op(malu_pkg::OP_SWAP, 3'h0, 8'h00, 8'ha5, 8'h00, 4'hf, 8'h00, 8'h5a, 10'h00f);
        run_op(malu_pkg::OP_SWAP_W, 3'h0, 8'h00, 8'h3c, 8'h00, 4'hf, 8'hc3, 8'h3c, 10'h00f);
        run_op(malu_pkg::OP_XOR, 3'h0, 8'h00, 8'hff, 8'h0f, 4'hf, 8'hf0, 8'hff, 10'h00b);
        run_op(malu_pkg::OP_XOR_IMM, 3'h0, 8'h5a, 8'h00, 8'h5a, 4'h0, 8'h00, 8'h00, 10'h004);
        run_op(malu_pkg::OP_XOR_M, 3'h0, 8'h00, 8'h0f, 8'h0f, 4'hb, 8'h0f, 8'h00, 10'h00f);
    endtask

    task automatic t_table();
        apb(1'b1, malu_pkg::OFF_PAGE, 32'h0000_0001);
        apb(1'b1, malu_pkg::OFF_TBLPTR, 32'h0000_0007);
        apb(1'b1, malu_pkg::OFF_PROG_PTR, 32'h0000_0107);
        apb(1'b1, malu_pkg::OFF_PROG_DATA, 32'h0000_abcd);
        apb(1'b1, malu_pkg::OFF_PROG_PTR, 32'h0000_0307);
        apb(1'b1, malu_pkg::OFF_PROG_DATA, 32'h0000_1234);
        run_op(malu_pkg::OP_TBL_CUR, 3'h0, 8'h00, 8'h00, 8'h00, 4'h0, 8'h00, 8'hcd, 10'h000);
        apb(1'b0, malu_pkg::OFF_TBLHIGH, 32'h0);
        chk(q, 32'h0000_00ab);
        run_op(malu_pkg::OP_TBL_LAST, 3'h0, 8'h00, 8'h00, 8'h00, 4'h0, 8'h00, 8'h34, 10'h000);
        apb(1'b0, malu_pkg::OFF_TBLHIGH, 32'h0);
        chk(q, 32'h0000_0012);
    endtask

    task automatic t_refuse();
        apb(1'b0, 8'h30, 32'h0);
        chk({31'h0, err}, 32'h0000_0001);
        chk(q, 32'h0000_0000);
        apb(1'b1, malu_pkg::OFF_INSTR, 32'h0000_0018);
        chk({31'h0, err}, 32'h0000_0001);
    endtask

    initial begin
        repeat (10) @(posedge clk_sys);
        reset_n <= 1'b1;
        t_arith();
        t_skip();
        t_freeze();
        t_misc();
        t_table();
        t_refuse();
        complete_run();
    end
endmodule
